// ---- ttp_pkg.sv ----
package ttp_pkg;

    localparam int ADDR_W = 8;
    localparam int NCH = 2;

    // Register word indices; byte address is four times the index
    localparam logic [5:0] IDX_TSC = 6'h10;
    localparam logic [5:0] IDX_CNT_H = 6'h11;
    localparam logic [5:0] IDX_CNT_L = 6'h12;
    localparam logic [5:0] IDX_MOD_H = 6'h13;
    localparam logic [5:0] IDX_MOD_L = 6'h14;
    localparam logic [5:0] IDX_CH0_SC = 6'h15;
    localparam logic [5:0] IDX_CH0_VH = 6'h16;
    localparam logic [5:0] IDX_CH0_VL = 6'h17;
    localparam logic [5:0] IDX_CH1_SC = 6'h18;
    localparam logic [5:0] IDX_CH1_VH = 6'h19;
    localparam logic [5:0] IDX_CH1_VL = 6'h1a;
    localparam logic [5:0] CH_STRIDE = 6'h03;

    // Timer status/control fields
    localparam int TSC_FLAG = 7;
    localparam int TSC_IE = 6;
    localparam int TSC_CPWM = 5;
    localparam int TSC_CLK_LO = 3;
    localparam int TSC_PS_LO = 0;

    // Channel status/control fields
    localparam int CSC_FLAG = 7;
    localparam int CSC_IE = 6;
    localparam int CSC_MODE_LO = 4;
    localparam int CSC_ELS_LO = 2;

    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_TOP = 16'hffff;
    localparam logic [1:0] MODE_CAPTURE = 2'b00;
    localparam logic [1:0] MODE_COMPARE = 2'b01;
    localparam logic [1:0] ELS_OFF = 2'b00;
    localparam logic [1:0] ELS_TOGGLE = 2'b01;
    localparam logic [1:0] ELS_CLEAR = 2'b10;
    localparam logic [1:0] ELS_SET = 2'b11;

    typedef enum logic [1:0] {
        CLK_OFF = 2'b00,
        CLK_BUS = 2'b01,
        CLK_FIXED = 2'b10,
        CLK_EXT = 2'b11
    } ttp_clk_e;

    typedef struct packed {
        logic flag;
        logic arm;
        logic ie;
        logic [1:0] mode;
        logic [1:0] els;
        logic [15:0] val;
        logic [15:0] vbuf;
        logic wr_h;
        logic wr_l;
        logic [15:0] rbuf;
        logic rd_lat;
        logic rd_first_hi;
        logic pin_out;
        logic pin_oe;
        logic irq;
    } ttp_ch_s;

    typedef struct packed {
        ttp_ch_s [NCH-1:0] ch;
        logic [15:0] cnt;
        logic dir_down;
        logic [15:0] modv;
        logic [15:0] mbuf;
        logic mod_wh;
        logic mod_wl;
        logic overflow_flag;
        logic tof_arm;
        logic overflow_irq_enable;
        logic center_pwm_select;
        ttp_clk_e clks;
        logic [2:0] ps;
        logic [6:0] psc;
        logic [15:0] clat;
        logic clat_v;
        logic clat_hi;
        logic [NCH-1:0] pin_s1;
        logic [NCH-1:0] pin_s2;
        logic [NCH-1:0] pin_d;
        logic ext_s1;
        logic ext_s2;
        logic ext_d;
        logic [7:0] prdata;
        logic pready;
        logic pslverr;
        logic ovf_irq;
    } ttp_state_s;

endpackage

// ---- ttp_core.sv ----
// Operation
// - Select code 00 releases pin from channel
// - Capture on rising, falling or both edges
// - Compare: flag only, toggle, clear, set
// - Edge PWM, polarity from select code
// - Center PWM, polarity from select code
// - Channel value readable, writable, resets zero
// - Capture read freezes both bytes until pair
// - Compare writes move after both bytes
// - Sixteen-bit counter, prescaler, modulus, channel pins
// - Center select makes counter up/down
// - Clock source off after reset
// - Counting halts in debug and stop
// - Up count wraps at terminal count
// - Up/down count, ends last one period
// - Overflow request follows flag when enabled
// - Up mode overflow flag at wrap
// - Up/down overflow flag at reversal from terminal count
// - Counter byte read freezes whole count
// - Counter write clears count and freeze
// - Event flag set; read then write clears
// - Channel request when flag and enable
`timescale 1ns/10ps
`default_nettype none

module ttp_core
    import ttp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] ch_pin_in,
    output logic [NCH-1:0] ch_pin_out,
    output logic [NCH-1:0] ch_pin_oe,
    input wire logic ext_clk_in,
    input wire logic fixed_clk_en,
    input wire logic debug_halt,
    input wire logic stop_mode,
    output logic ovf_irq,
    output logic [NCH-1:0] ch_irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] div_max(input logic [2:0] ps);
        div_max = 7'((8'h01 << ps) - 8'h01);
    endfunction

    function automatic logic [5:0] ch_idx(input int i, input logic [5:0] base);
        ch_idx = 6'(base + CH_STRIDE * 6'(i));
    endfunction

    // Byte select: returns high or low byte of v, keeps no state
    function automatic logic [7:0] pick(input logic [15:0] v, input logic hi);
        pick = hi ? v[15:8] : v[7:0];
    endfunction

    ttp_state_s s_r;
    ttp_state_s s_nxt;

    logic src;
    logic tick;
    logic ovf_evt;
    logic [15:0] term;
    logic [5:0] idx;
    logic setup;
    logic access;
    logic mapped;
    logic [7:0] rd;
    logic [7:0] wd;
    logic capt;
    logic cmp;
    logic epwm;
    logic evt;
    logic match;
    logic rise;
    logic fall;
    logic active;

    always_comb begin
        s_nxt = s_r;
        src = 1'b0;
        tick = 1'b0;
        ovf_evt = 1'b0;
        term = (s_r.modv == CNT_RST) ? CNT_TOP : s_r.modv;
        idx = (paddr[1:0] == 2'b00) ? paddr[7:2] : 6'h00;
        setup = psel & ~penable;
        access = psel & penable & s_r.pready;
        mapped = 1'b0;
        rd = 8'h00;
        wd = pwdata[7:0];
        capt = 1'b0;
        cmp = 1'b0;
        epwm = 1'b0;
        evt = 1'b0;
        match = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        active = 1'b0;

        // ------------------------------------------------------------
        // Input synchronisers
        // ------------------------------------------------------------
        s_nxt.pin_s1 = ch_pin_in;
        s_nxt.pin_s2 = s_r.pin_s1;
        s_nxt.pin_d = s_r.pin_s2;
        s_nxt.ext_s1 = ext_clk_in;
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.ext_d = s_r.ext_s2;

        // ------------------------------------------------------------
        // Clock source and prescaler
        // ------------------------------------------------------------
        // source select
        unique case (s_r.clks)
            CLK_OFF: src = 1'b0;
            CLK_BUS: src = 1'b1;
            CLK_FIXED: src = fixed_clk_en;
            CLK_EXT: src = s_r.ext_s2 & ~s_r.ext_d;
        endcase
        if (debug_halt | stop_mode) begin
            src = 1'b0;
        end
        if (src) begin
            if (s_r.psc >= div_max(s_r.ps)) begin
                s_nxt.psc = 7'h00;
                tick = 1'b1;
            end else begin
                s_nxt.psc = 7'(s_r.psc + 7'h01);
            end
        end

        // ------------------------------------------------------------
        // Main counter
        // ------------------------------------------------------------
        if (tick) begin
            if (s_r.center_pwm_select) begin
                if (!s_r.dir_down) begin
                    if (s_r.cnt >= term) begin
                        s_nxt.dir_down = 1'b1;
                        s_nxt.cnt = 16'(s_r.cnt - 16'h0001);
                        ovf_evt = 1'b1;
                    end else begin
                        s_nxt.cnt = 16'(s_r.cnt + 16'h0001);
                    end
                end else if (s_r.cnt == CNT_RST) begin
                    s_nxt.dir_down = 1'b0;
                    s_nxt.cnt = 16'(s_r.cnt + 16'h0001);
                end else begin
                    s_nxt.cnt = 16'(s_r.cnt - 16'h0001);
                end
            end else begin
                s_nxt.dir_down = 1'b0;
                if (s_r.cnt >= term) begin
                    s_nxt.cnt = CNT_RST;
                    ovf_evt = 1'b1;
                end else begin
                    s_nxt.cnt = 16'(s_r.cnt + 16'h0001);
                end
            end
        end

        // ------------------------------------------------------------
        // APB slave
        // ------------------------------------------------------------
        s_nxt.pready = setup;
        if (setup) begin
            unique case (idx)
                IDX_TSC: begin
                    mapped = 1'b1;
                    rd = {s_r.overflow_flag, s_r.overflow_irq_enable, s_r.center_pwm_select, s_r.clks, s_r.ps};
                    if (!pwrite && s_r.overflow_flag) begin
                        s_nxt.tof_arm = 1'b1;
                    end
                end
                IDX_CNT_H, IDX_CNT_L: begin
                    mapped = 1'b1;
                    if (!pwrite) begin
                        if (!s_r.clat_v) begin
                            rd = pick(s_r.cnt, idx == IDX_CNT_H);
                            s_nxt.clat = s_r.cnt;
                            s_nxt.clat_v = 1'b1;
                            s_nxt.clat_hi = (idx == IDX_CNT_H);
                        end else begin
                            rd = pick(s_r.clat, idx == IDX_CNT_H);
                            if (s_r.clat_hi != (idx == IDX_CNT_H)) begin
                                s_nxt.clat_v = 1'b0;
                            end
                        end
                    end
                end
                IDX_MOD_H: begin
                    mapped = 1'b1;
                    rd = s_r.modv[15:8];
                end
                IDX_MOD_L: begin
                    mapped = 1'b1;
                    rd = s_r.modv[7:0];
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (idx == ch_idx(i, IDX_CH0_SC)) begin
                    mapped = 1'b1;
                    rd = {s_r.ch[i].flag, s_r.ch[i].ie, s_r.ch[i].mode, s_r.ch[i].els, 2'b00};
                    if (!pwrite && s_r.ch[i].flag) begin
                        s_nxt.ch[i].arm = 1'b1;
                    end
                end
                if (idx == ch_idx(i, IDX_CH0_VH) || idx == ch_idx(i, IDX_CH0_VL)) begin
                    mapped = 1'b1;
                    rd = pick(s_r.ch[i].val, idx == ch_idx(i, IDX_CH0_VH));
                    if (!pwrite && !s_r.center_pwm_select && s_r.ch[i].mode == MODE_CAPTURE) begin
                        if (!s_r.ch[i].rd_lat) begin
                            s_nxt.ch[i].rbuf = s_r.ch[i].val;
                            s_nxt.ch[i].rd_lat = 1'b1;
                            s_nxt.ch[i].rd_first_hi = (idx == ch_idx(i, IDX_CH0_VH));
                        end else begin
                            rd = pick(s_r.ch[i].rbuf, idx == ch_idx(i, IDX_CH0_VH));
                            if (s_r.ch[i].rd_first_hi != (idx == ch_idx(i, IDX_CH0_VH))) begin
                                s_nxt.ch[i].rd_lat = 1'b0;
                            end
                        end
                    end
                end
            end
            s_nxt.prdata = (pwrite || !mapped) ? 8'h00 : rd;
            s_nxt.pslverr = ~mapped | (paddr[1:0] != 2'b00);
        end

        if (access && pwrite && !s_r.pslverr) begin
            unique case (idx)
                IDX_TSC: begin
                    if (s_r.tof_arm && !wd[TSC_FLAG]) begin
                        s_nxt.overflow_flag = 1'b0;
                    end
                    s_nxt.tof_arm = 1'b0;
                    s_nxt.overflow_irq_enable = wd[TSC_IE];
                    s_nxt.center_pwm_select = wd[TSC_CPWM];
                    s_nxt.clks = ttp_clk_e'(wd[TSC_CLK_LO +: 2]);
                    s_nxt.ps = wd[TSC_PS_LO +: 3];
                    s_nxt.mod_wh = 1'b0;
                    s_nxt.mod_wl = 1'b0;
                end
                IDX_CNT_H, IDX_CNT_L: begin
                    s_nxt.cnt = CNT_RST;
                    s_nxt.dir_down = 1'b0;
                    s_nxt.psc = 7'h00;
                    s_nxt.clat_v = 1'b0;
                end
                IDX_MOD_H: begin
                    s_nxt.mbuf[15:8] = wd;
                    s_nxt.mod_wh = 1'b1;
                end
                IDX_MOD_L: begin
                    s_nxt.mbuf[7:0] = wd;
                    s_nxt.mod_wl = 1'b1;
                end
                default: begin
                    s_nxt.mod_wh = s_nxt.mod_wh;
                end
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (idx == ch_idx(i, IDX_CH0_SC)) begin
                    if (s_r.ch[i].arm && !wd[CSC_FLAG]) begin
                        s_nxt.ch[i].flag = 1'b0;
                    end
                    s_nxt.ch[i].arm = 1'b0;
                    s_nxt.ch[i].ie = wd[CSC_IE];
                    s_nxt.ch[i].mode = wd[CSC_MODE_LO +: 2];
                    s_nxt.ch[i].els = wd[CSC_ELS_LO +: 2];
                    s_nxt.ch[i].rd_lat = 1'b0;
                    s_nxt.ch[i].wr_h = 1'b0;
                    s_nxt.ch[i].wr_l = 1'b0;
                end
                if (idx == ch_idx(i, IDX_CH0_VH)) begin
                    s_nxt.ch[i].vbuf[15:8] = wd;
                    s_nxt.ch[i].wr_h = 1'b1;
                end
                if (idx == ch_idx(i, IDX_CH0_VL)) begin
                    s_nxt.ch[i].vbuf[7:0] = wd;
                    s_nxt.ch[i].wr_l = 1'b1;
                end
            end
        end

        if (s_nxt.mod_wh && s_nxt.mod_wl) begin
            s_nxt.modv = s_nxt.mbuf;
            s_nxt.mod_wh = 1'b0;
            s_nxt.mod_wl = 1'b0;
        end

        // ------------------------------------------------------------
        // Overflow flag; a new event beats a pending clear
        // ------------------------------------------------------------
        if (ovf_evt) begin
            s_nxt.overflow_flag = 1'b1;
            s_nxt.tof_arm = 1'b0;
        end
        s_nxt.ovf_irq = s_nxt.overflow_flag & s_nxt.overflow_irq_enable;

        // ------------------------------------------------------------
        // Channels
        // ------------------------------------------------------------
        for (int i = 0; i < NCH; i++) begin
            capt = !s_r.center_pwm_select && s_r.ch[i].mode == MODE_CAPTURE;
            cmp = !s_r.center_pwm_select && s_r.ch[i].mode == MODE_COMPARE;
            epwm = !s_r.center_pwm_select && s_r.ch[i].mode[1];
            active = ~s_r.ch[i].els[0];
            match = tick && s_r.cnt == s_r.ch[i].val;
            rise = s_r.pin_s2[i] & ~s_r.pin_d[i];
            fall = ~s_r.pin_s2[i] & s_r.pin_d[i];
            evt = 1'b0;
            if (capt) begin
                if ((s_r.ch[i].els[0] & rise) | (s_r.ch[i].els[1] & fall)) begin
                    s_nxt.ch[i].val = s_r.cnt;
                    evt = 1'b1;
                end
            end else if (match) begin
                evt = 1'b1;
            end
            if (cmp && match) begin
                unique case (s_r.ch[i].els)
                    ELS_OFF: s_nxt.ch[i].pin_out = s_r.ch[i].pin_out;
                    ELS_TOGGLE: s_nxt.ch[i].pin_out = ~s_r.ch[i].pin_out;
                    ELS_CLEAR: s_nxt.ch[i].pin_out = 1'b0;
                    ELS_SET: s_nxt.ch[i].pin_out = 1'b1;
                endcase
            end
            if (epwm && s_r.ch[i].els != ELS_OFF) begin
                if (match) begin
                    s_nxt.ch[i].pin_out = ~active;
                end
                if (ovf_evt) begin
                    s_nxt.ch[i].pin_out = (s_r.ch[i].val != CNT_RST) ? active : ~active;
                end
            end
            if (s_r.center_pwm_select && s_r.ch[i].els != ELS_OFF) begin
                if (s_r.ch[i].val == CNT_RST || s_r.ch[i].val[15]) begin
                    s_nxt.ch[i].pin_out = ~active;
                end else if (match) begin
                    s_nxt.ch[i].pin_out = s_r.dir_down ? active : ~active;
                end
            end
            if (s_nxt.ch[i].wr_h && s_nxt.ch[i].wr_l && (!(epwm || s_r.center_pwm_select) || ovf_evt)) begin
                s_nxt.ch[i].val = s_nxt.ch[i].vbuf;
                s_nxt.ch[i].wr_h = 1'b0;
                s_nxt.ch[i].wr_l = 1'b0;
            end
            if (evt) begin
                s_nxt.ch[i].flag = 1'b1;
                s_nxt.ch[i].arm = 1'b0;
            end
            s_nxt.ch[i].pin_oe = (s_nxt.ch[i].els != ELS_OFF) &&
                (s_nxt.center_pwm_select || s_nxt.ch[i].mode != MODE_CAPTURE);
            s_nxt.ch[i].irq = s_nxt.ch[i].flag & s_nxt.ch[i].ie;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = {24'h000000, s_r.prdata};
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign ovf_irq = s_r.ovf_irq;

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign ch_pin_out[g] = s_r.ch[g].pin_out;
        assign ch_pin_oe[g] = s_r.ch[g].pin_oe;
        assign ch_irq[g] = s_r.ch[g].irq;
    end

endmodule

`default_nettype wire

// ---- ttp_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----
// Pin side model
// ----
module ttp_pin_model (
    input wire logic clk,
    input wire logic [1:0] lvl,
    input wire logic [1:0] dout,
    input wire logic [1:0] oe,
    output logic [1:0] pin,
    output logic ext
);
    logic [1:0] held = 2'b00;
    always @(posedge clk) begin
        held <= lvl;
    end
    // Wire level from both drivers
    assign pin = (oe & dout) | (~oe & held);
    assign ext = 1'b0;
endmodule
`default_nettype wire

// ---- ttp_core_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checker
// ----
module ttp_core_assertions
    import ttp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NCH-1:0] ch_pin_oe,
    input wire logic ovf_irq,
    input wire logic [NCH-1:0] ch_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic setup;
    logic sc_wr;
    logic ie_r;
    assign setup = psel && !penable;
    assign sc_wr = pready && pwrite && paddr == {IDX_CH1_SC, 2'b00};
    // Last written overflow enable
    always_ff @(posedge clk) begin
        if (srst) begin
            ie_r <= 1'b0;
        end else if (pready && pwrite && paddr == {IDX_TSC, 2'b00}) begin
            ie_r <= pwdata[TSC_IE];
        end
    end
    ready_after_setup_a: assert property (setup |=> pready)
        else $error("pready missing after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    no_stray_ready_a: assert property (!setup |=> !pready)
        else $error("pready without setup");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("prdata upper bits set");
    bad_addr_a: assert property (setup && (paddr[1:0] != 2'b00
        || paddr[7:2] < IDX_TSC || paddr[7:2] > IDX_CH1_VL) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    reset_quiet_a: assert property ($fell(srst) |-> ch_pin_oe == '0
        && !ovf_irq && ch_irq == '0)
        else $error("outputs active after reset");
    irq_gate_a: assert property (!ie_r && !$past(ie_r) |-> !ovf_irq)
        else $error("overflow request while disabled");
    pin_release_a: assert property (sc_wr && pwdata[3:2] == ELS_OFF
        |-> ##[1:2] !ch_pin_oe[1])
        else $error("pin not released");
    pwm_drive_a: assert property (sc_wr && pwdata[5] && pwdata[3:2] != ELS_OFF
        |-> ##[1:2] ch_pin_oe[1])
        else $error("pwm pin not driven");
    cover property (ovf_irq);
    cover property (ch_irq[1]);
    cover property (sc_wr && pwdata[5]);
endmodule
bind ttp_core ttp_core_assertions chk (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ch_pin_oe, .ovf_irq, .ch_irq);
`default_nettype wire

// ---- test_two_channel_timer_pwm_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_two_channel_timer_pwm_core
    import ttp_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ovf_irq, ext_clk, er;
    logic dbg = 1'b0;
    logic stp = 1'b0;
    logic fx = 1'b0;
    logic [1:0] pin_in, pin_out, pin_oe, ch_irq;
    logic [1:0] lvl = 2'b00;
    logic [7:0] rd, a, cfg;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    logic [5:0] rl [5] = '{IDX_TSC, IDX_CH1_SC, IDX_CH1_VH, IDX_CH1_VL, IDX_CNT_L};
    ttp_core uut (
        .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe), .ext_clk_in(ext_clk),
        .fixed_clk_en(fx), .debug_halt(dbg), .stop_mode(stp), .ovf_irq, .ch_irq
    );
    ttp_pin_model pins (.clk, .lvl, .dout(pin_out), .oe(pin_oe), .pin(pin_in), .ext(ext_clk));
    // ----
    // Clock, timeout, tasks
    // ----
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        fx <= ~fx;
        if (cyc == 5000) begin
            err_count++;
            $display("Error at %0t: timeout", $time);
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        xfer(1'b1, {i, 2'b00}, d);
    endtask
    task automatic rdx(input logic [5:0] i);
        xfer(1'b0, {i, 2'b00}, 8'h00);
    endtask
    task automatic rdc(input logic [5:0] i, input logic [7:0] e);
        rdx(i);
        chk(rd, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic oe_chk(input logic [1:0] e);
        @(negedge clk);
        chk({6'h0, pin_oe}, {6'h0, e});
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) rdc(rl[i], 8'h00);
        oe_chk(2'b00);
        xfer(1'b0, 8'h04, 8'h00);
        chk({7'h0, er}, 8'h01);
        xfer(1'b0, 8'h41, 8'h00);
        chk({7'h0, er}, 8'h01);
        chk(rd, 8'h00);
        wt(10);
        rdc(IDX_CNT_H, 8'h00);
        rdc(IDX_CNT_L, 8'h00);
        wr(IDX_TSC, 8'h08);
        wt(20);
        rdx(IDX_CNT_L);
        a = rd;
        wt(5);
        rdc(IDX_CNT_L, a);
        rdx(IDX_CNT_H);
        rdx(IDX_CNT_L);
        chk({7'h0, rd !== a}, 8'h01);
        rdx(IDX_CNT_H);
        wr(IDX_CNT_H, 8'h5a);
        rdx(IDX_CNT_L);
        chk({7'h0, rd < 8'h08}, 8'h01);
        rdc(IDX_CNT_H, 8'h00);
        dbg <= 1'b1;
        wt(2);
        rdx(IDX_CNT_L);
        a = rd;
        rdx(IDX_CNT_H);
        wt(10);
        rdc(IDX_CNT_L, a);
        rdx(IDX_CNT_H);
        dbg <= 1'b0;
        stp <= 1'b1;
        wt(5);
        rdc(IDX_CNT_L, a);
        rdx(IDX_CNT_H);
        stp <= 1'b0;
        wr(IDX_TSC, 8'h11);
        wr(IDX_CNT_L, 8'h00);
        wt(38);
        rdx(IDX_CNT_L);
        chk({7'h0, rd >= 8'h08 && rd <= 8'h0c}, 8'h01);
        rdx(IDX_CNT_H);
        wr(IDX_TSC, 8'h08);
        wr(IDX_MOD_H, 8'h00);
        wr(IDX_MOD_L, 8'h05);
        wr(IDX_CNT_L, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rdx(IDX_CNT_L);
            chk({7'h0, rd <= 8'h05}, 8'h01);
            rdx(IDX_CNT_H);
        end
        rdc(IDX_TSC, 8'h88);
        wr(IDX_TSC, 8'h48);
        wt(10);
        @(negedge clk);
        chk({7'h0, ovf_irq}, 8'h01);
        wr(IDX_TSC, 8'hc0);
        rdx(IDX_TSC);
        wr(IDX_TSC, 8'h40);
        rdc(IDX_TSC, 8'h40);
        chk({7'h0, ovf_irq}, 8'h00);
        wr(IDX_TSC, 8'h28);
        wt(20);
        rdc(IDX_TSC, 8'ha8);
        wr(IDX_TSC, 8'h00);
        wr(IDX_CH1_SC, 8'h14);
        wr(IDX_CH1_VH, 8'h12);
        rdc(IDX_CH1_VH, 8'h00);
        wr(IDX_CH1_VL, 8'h03);
        rdc(IDX_CH1_VH, 8'h12);
        rdc(IDX_CH1_VL, 8'h03);
        wr(IDX_CH1_VH, 8'h56);
        wr(IDX_CH1_SC, 8'h14);
        wr(IDX_CH1_VL, 8'h04);
        rdc(IDX_CH1_VH, 8'h12);
        rdc(IDX_CH1_VL, 8'h03);
        oe_chk(2'b10);
        wr(IDX_CH1_SC, 8'h14);
        wr(IDX_CH1_VH, 8'h00);
        wr(IDX_CH1_VL, 8'h03);
        wr(IDX_TSC, 8'h08);
        wt(10);
        wr(IDX_TSC, 8'h00);
        rdc(IDX_CH1_SC, 8'h94);
        wr(IDX_CH1_SC, 8'h14);
        rdc(IDX_CH1_SC, 8'h14);
        wr(IDX_CH1_SC, 8'h1c);
        wr(IDX_TSC, 8'h08);
        wt(10);
        wr(IDX_TSC, 8'h00);
        @(negedge clk);
        chk({6'h0, pin_out}, 8'h02);
        wr(IDX_MOD_H, 8'h00);
        wr(IDX_MOD_L, 8'h00);
        wr(IDX_TSC, 8'h08);
        for (int e = 1; e < 4; e++) begin
            cfg = {4'h4, e[1:0], 2'b00};
            wr(IDX_CH1_SC, cfg);
            rdx(IDX_CH1_SC);
            wr(IDX_CH1_SC, cfg);
            lvl <= 2'b10;
            wt(8);
            rdc(IDX_CH1_SC, {e[0], cfg[6:0]});
            @(negedge clk);
            chk({6'h0, ch_irq}, {6'h0, e[0], 1'b0});
            wr(IDX_CH1_SC, cfg);
            lvl <= 2'b00;
            wt(8);
            rdc(IDX_CH1_SC, {e[1], cfg[6:0]});
        end
        rdx(IDX_CH1_VH);
        rdx(IDX_CH1_VL);
        a = rd;
        rdx(IDX_CH1_VH);
        lvl <= 2'b10;
        wt(8);
        rdc(IDX_CH1_VL, a);
        rdx(IDX_CH1_VL);
        chk({7'h0, rd !== a}, 8'h01);
        lvl <= 2'b00;
        wr(IDX_CH1_SC, 8'h20);
        oe_chk(2'b00);
        wr(IDX_CH1_SC, 8'h28);
        oe_chk(2'b10);
        wr(IDX_CH1_SC, 8'h08);
        wr(IDX_TSC, 8'h28);
        oe_chk(2'b10);
        wr(IDX_CH1_SC, 8'h00);
        oe_chk(2'b00);
        end_of_test();
    end
endmodule
`default_nettype wire
